//--- pkg/srt_pkg.sv
// Shared constants and state types for the split reload timer.
// Assumes one system clock; all users import the whole package.

package srt_pkg;

  // ------------------------------------------------------------
  // Bus and register map
  // ------------------------------------------------------------
  localparam int unsigned SRT_ADDR_W = 8;
  localparam int unsigned SRT_DATA_W = 32;
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_CKSEL  = 8'h04;
  localparam logic [7:0]  OFS_IEN    = 8'h08;
  localparam logic [7:0]  OFS_CNT_LO = 8'h0C;
  localparam logic [7:0]  OFS_CNT_HI = 8'h10;
  localparam logic [7:0]  OFS_RLD_LO = 8'h14;
  localparam logic [7:0]  OFS_RLD_HI = 8'h18;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int unsigned CTL_HFLAG = 7;
  localparam int unsigned CTL_LFLAG = 6;
  localparam int unsigned CTL_LIEN  = 5;
  localparam int unsigned CTL_CAPEN = 4;
  localparam int unsigned CTL_SPLIT = 3;
  localparam int unsigned CTL_RUN   = 2;
  localparam int unsigned CTL_XCLK  = 0;
  localparam int unsigned CK_HSEL   = 5;
  localparam int unsigned CK_LSEL   = 4;
  localparam int unsigned IEN_TMR   = 5;

  // ------------------------------------------------------------
  // Counting constants
  // ------------------------------------------------------------
  localparam logic [7:0]  BYTE_MAX  = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [15:0] CNT_ONE   = 16'h0001;
  localparam int unsigned SYS_DIV   = 12;
  localparam int unsigned EXT_DIV   = 8;

  // ------------------------------------------------------------
  // State types
  // ------------------------------------------------------------
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_byte_irq_enable;
    logic capture_enable;
    logic split_mode_select;
    logic run_control;
    logic external_clock_select;
  } srt_ctrl_s;

  typedef struct packed {
    logic high_half_clock_select;
    logic low_half_clock_select;
  } srt_cksel_s;

  typedef struct packed {
    logic div12;
    logic ext_rise;
    logic ext_fall;
  } srt_tick_s;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } srt_presc_s;

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       prev;
    logic [2:0] div;
    logic       rise;
    logic       fall;
  } srt_ext_s;

  typedef struct packed {
    srt_ctrl_s  ctrl;
    srt_cksel_s cksel;
    logic       timer_irq_enable;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic       irq;
    logic       aw_got;
    logic [7:0] aw_addr;
    logic       w_got;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } srt_state_s;

endpackage

//--- src/srt_presc.sv
// System clock prescaler giving a one-cycle tick every DIV cycles.
// Assumes aclk is the system clock and ce freezes it.

`timescale 1ns/100ps

module srt_presc
  import srt_pkg::*;
#(
  parameter int unsigned DIV = SYS_DIV
)(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  output logic      tick
);

  srt_presc_s s_q;
  srt_presc_s s_d;

  always_comb
  begin
    s_d = s_q;
    if (ce)
    begin
      s_d.tick = (s_q.cnt == 4'(DIV - 1));
      s_d.cnt  = s_d.tick ? 4'h0 : 4'(s_q.cnt + 4'h1);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick & ce;

endmodule // srt_presc

//--- src/srt_ext_div.sv
// External oscillator: synchroniser, divide by 8, edge pulses.
// Assumes the oscillator is far slower than aclk.

`timescale 1ns/100ps

module srt_ext_div
  import srt_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic ext_osc,
  output logic      rise,
  output logic      fall
);

  srt_ext_s s_q;
  srt_ext_s s_d;

  always_comb
  begin
    s_d = s_q;
    if (ce)
    begin
      s_d.sync1 = ext_osc;
      s_d.sync2 = s_q.sync1;
      s_d.prev  = s_q.sync2;
      s_d.rise  = 1'b0;
      s_d.fall  = 1'b0;
      if (s_q.sync2 && !s_q.prev)
      begin
        s_d.div  = 3'(s_q.div + 3'h1);
        // Divided clock is div[2]: rises 3->4, falls 7->0
        s_d.rise = (s_q.div == 3'(EXT_DIV / 2 - 1));
        s_d.fall = (s_q.div == 3'(EXT_DIV - 1));
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign rise = s_q.rise & ce;
  assign fall = s_q.fall & ce;

endmodule // srt_ext_div

//--- src/srt_timer.sv
// Split reload timer with external oscillator capture, AXI4-Lite slave.
// Assumes a single system clock aclk and an asynchronous oscillator pin.

`timescale 1ns/100ps

module srt_timer
  import srt_pkg::*;
#(
  parameter int unsigned ADDR_W = SRT_ADDR_W
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic              ext_osc,
  output logic                   irq,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ------------------------------------------------------------
  // Clock sources
  // ------------------------------------------------------------
  srt_tick_s  tk;
  srt_state_s s_q;
  srt_state_s s_d;

  srt_presc #(
    .DIV     (SYS_DIV)
  ) u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .tick    (tk.div12)
  );

  // Oscillator is resynchronised inside before any edge is taken
  srt_ext_div u_ext (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .ext_osc (ext_osc),
    .rise    (tk.ext_rise),
    .fall    (tk.ext_fall)
  );

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_go;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane0;

  assign s_axi_awready = ce & ~s_q.aw_got & ~s_q.bvalid;
  assign s_axi_wready  = ce & ~s_q.w_got & ~s_q.bvalid;
  assign s_axi_arready = ce & ~s_q.rvalid;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign ar_take       = s_axi_arvalid & s_axi_arready;
  // Address and data may arrive in either order or together
  assign wr_go    = (s_q.aw_got | aw_take) & (s_q.w_got | w_take) & ~s_q.bvalid & ce;
  assign wr_addr  = s_q.aw_got ? s_q.aw_addr : 8'(s_axi_awaddr);
  assign wr_byte  = s_q.w_got ? s_q.w_data : s_axi_wdata[7:0];
  assign wr_lane0 = s_q.w_got ? s_q.w_lane0 : s_axi_wstrb[0];

  // ------------------------------------------------------------
  // Count clock selection
  // ------------------------------------------------------------
  logic tick_lo;
  logic tick_hi;
  logic tick_16;

  always_comb
  begin
    tick_lo = s_q.ctrl.external_clock_select ? tk.ext_rise : tk.div12;
    tick_hi = tick_lo;
    if (s_q.cksel.low_half_clock_select)
      tick_lo = 1'b1;
    if (s_q.cksel.high_half_clock_select)
      tick_hi = 1'b1;
    // Oscillator is the measured signal in capture mode, never the 16-bit count clock
    if (s_q.ctrl.capture_enable)
      tick_16 = s_q.cksel.low_half_clock_select | tk.div12;
    else
      tick_16 = tick_lo;
  end

  // ------------------------------------------------------------
  // Register read mux
  // ------------------------------------------------------------
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [7:0]  rd_addr;

  assign rd_addr = 8'(s_axi_araddr);

  always_comb
  begin
    rd_word = WORD_ZERO;
    rd_hit  = 1'b1;
    case (rd_addr)
      OFS_CTRL:
      begin
        rd_word[CTL_HFLAG] = s_q.ctrl.high_overflow_flag;
        rd_word[CTL_LFLAG] = s_q.ctrl.low_overflow_flag;
        rd_word[CTL_LIEN]  = s_q.ctrl.low_byte_irq_enable;
        rd_word[CTL_CAPEN] = s_q.ctrl.capture_enable;
        rd_word[CTL_SPLIT] = s_q.ctrl.split_mode_select;
        rd_word[CTL_RUN]   = s_q.ctrl.run_control;
        rd_word[CTL_XCLK]  = s_q.ctrl.external_clock_select;
      end
      OFS_CKSEL:
      begin
        rd_word[CK_HSEL] = s_q.cksel.high_half_clock_select;
        rd_word[CK_LSEL] = s_q.cksel.low_half_clock_select;
      end
      OFS_IEN:
        rd_word[IEN_TMR] = s_q.timer_irq_enable;
      OFS_CNT_LO:
        rd_word[7:0] = s_q.count_low_byte;
      OFS_CNT_HI:
        rd_word[7:0] = s_q.count_high_byte;
      OFS_RLD_LO:
        rd_word[7:0] = s_q.reload_low_byte;
      OFS_RLD_HI:
        rd_word[7:0] = s_q.reload_high_byte;
      default:
        rd_hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic [15:0] cnt16;
  logic [15:0] cnt16_nx;
  logic        set_h;
  logic        set_l;

  assign cnt16    = {s_q.count_high_byte, s_q.count_low_byte};
  assign cnt16_nx = 16'(cnt16 + CNT_ONE);

  always_comb
  begin
    s_d   = s_q;
    set_h = 1'b0;
    set_l = 1'b0;
    if (ce)
    begin
      // Timer counting
      if (!s_q.ctrl.split_mode_select)
      begin
        if (s_q.ctrl.run_control && tick_16)
        begin
          {s_d.count_high_byte, s_d.count_low_byte} = cnt16_nx;
          if (s_q.count_low_byte == BYTE_MAX)
            set_l = 1'b1;
          if (cnt16 == {BYTE_MAX, BYTE_MAX})
          begin
            set_h = 1'b1;
            // Capture owns the reload pair, so the count simply wraps
            if (!s_q.ctrl.capture_enable)
            begin
              s_d.count_high_byte = s_q.reload_high_byte;
              s_d.count_low_byte  = s_q.reload_low_byte;
            end
          end
        end
      end
      else
      begin
        // Low byte ignores the run bit in split mode
        if (tick_lo)
        begin
          if (s_q.count_low_byte == BYTE_MAX)
          begin
            s_d.count_low_byte = s_q.reload_low_byte;
            set_l = 1'b1;
          end
          else
            s_d.count_low_byte = 8'(s_q.count_low_byte + 8'h01);
        end
        if (s_q.ctrl.run_control && tick_hi)
        begin
          if (s_q.count_high_byte == BYTE_MAX)
          begin
            s_d.count_high_byte = s_q.reload_high_byte;
            set_h = 1'b1;
          end
          else
            s_d.count_high_byte = 8'(s_q.count_high_byte + 8'h01);
        end
      end

      // Capture on the falling edge of oscillator/8; counting goes on
      if (s_q.ctrl.capture_enable && tk.ext_fall)
      begin
        s_d.reload_high_byte = s_q.count_high_byte;
        s_d.reload_low_byte  = s_q.count_low_byte;
        set_h = 1'b1;
      end

      // Write channel
      if (aw_take)
      begin
        s_d.aw_got  = 1'b1;
        s_d.aw_addr = 8'(s_axi_awaddr);
      end
      if (w_take)
      begin
        s_d.w_got   = 1'b1;
        s_d.w_data  = s_axi_wdata[7:0];
        s_d.w_lane0 = s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        s_d.aw_got = 1'b0;
        s_d.w_got  = 1'b0;
        s_d.bvalid = 1'b1;
        s_d.bresp  = RESP_OKAY;
        case (wr_addr)
          OFS_CTRL:
            if (wr_lane0)
            begin
              s_d.ctrl.high_overflow_flag    = wr_byte[CTL_HFLAG];
              s_d.ctrl.low_overflow_flag     = wr_byte[CTL_LFLAG];
              s_d.ctrl.low_byte_irq_enable   = wr_byte[CTL_LIEN];
              s_d.ctrl.capture_enable        = wr_byte[CTL_CAPEN];
              s_d.ctrl.split_mode_select     = wr_byte[CTL_SPLIT];
              s_d.ctrl.run_control           = wr_byte[CTL_RUN];
              s_d.ctrl.external_clock_select = wr_byte[CTL_XCLK];
            end
          OFS_CKSEL:
            if (wr_lane0)
            begin
              s_d.cksel.high_half_clock_select = wr_byte[CK_HSEL];
              s_d.cksel.low_half_clock_select  = wr_byte[CK_LSEL];
            end
          OFS_IEN:
            if (wr_lane0)
              s_d.timer_irq_enable = wr_byte[IEN_TMR];
          // Software write beats a same-cycle count or capture
          OFS_CNT_LO:
            if (wr_lane0)
              s_d.count_low_byte = wr_byte;
          OFS_CNT_HI:
            if (wr_lane0)
              s_d.count_high_byte = wr_byte;
          OFS_RLD_LO:
            if (wr_lane0)
              s_d.reload_low_byte = wr_byte;
          OFS_RLD_HI:
            if (wr_lane0)
              s_d.reload_high_byte = wr_byte;
          default:
            s_d.bresp = RESP_SLVERR;
        endcase
      end
      if (s_q.bvalid && s_axi_bready)
        s_d.bvalid = 1'b0;

      // Hardware only sets flags, and a set beats a software clear
      if (set_h)
        s_d.ctrl.high_overflow_flag = 1'b1;
      if (set_l)
        s_d.ctrl.low_overflow_flag = 1'b1;

      // Read channel
      if (ar_take)
      begin
        s_d.rvalid = 1'b1;
        s_d.rdata  = rd_word;
        s_d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_q.rvalid && s_axi_rready)
        s_d.rvalid = 1'b0;

      // Interrupt from flags; low flag counts only with its enable
      s_d.irq = s_d.timer_irq_enable & (s_d.ctrl.high_overflow_flag
                | (s_d.ctrl.low_byte_irq_enable & s_d.ctrl.low_overflow_flag));
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign irq          = s_q.irq;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp  = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata  = s_q.rdata;
  assign s_axi_rresp  = s_q.rresp;

endmodule // srt_timer

//--- verif/srt_timer_props.sv
// Bus handshake and interrupt timing checks for the split reload timer.
// Assumes it is bound to srt_timer and sees only that module's ports.

`timescale 1ns/100ps

module srt_timer_chk
  import srt_pkg::*;
#(
  parameter int unsigned ADDR_W = SRT_ADDR_W
)(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              irq,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before accepted");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before accepted");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken with read pending");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken with response pending");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid && (s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR))
    else $error("write answer late");
  AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFS_RLD_HI
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == WORD_ZERO)
    else $error("unmapped read not refused");
  // Flags only clear by software; irq falls at the same edge the write response rises
  AST_IRQ_STICKY: assert property ($fell(irq) |-> s_axi_bvalid)
    else $error("irq fell without a write");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(irq));
endmodule // srt_timer_chk

bind srt_timer srt_timer_chk #(.ADDR_W(ADDR_W)) srt_timer_chk_i (.aclk, .aresetn, .irq, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

//--- verif/tb.sv
// Self-checking bench for the split reload timer over AXI4-Lite.
// Assumes the checker is bound in; the prot inputs stay fixed and ce drops only in the capture test.

`timescale 1ns/100ps

module tb
  import srt_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, ext_osc = 1'b0, ext_en = 1'b0, irq;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  logic [31:0] rd_d;
  logic [15:0] cap, cnt;
  int          num_errors = 0, check_count = 0, osc_n = 0;

  always #25 aclk = ~aclk;

  // Oscillator of ten aclk periods, so its divide by 8 ticks every 80 cycles
  always @(posedge aclk)
    if (ext_en)
    begin
      osc_n <= (osc_n == 4) ? 0 : osc_n + 1;
      if (osc_n == 4) ext_osc <= ~ext_osc;
    end

  srt_timer srt_timer_i (.aclk, .aresetn, .ce, .ext_osc, .irq, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic summarize();
    $display("Checks made %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    // Late ready keeps the response waiting one cycle, so its hold is exercised
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    wr_r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk(n, {8'h00, rd_d[7:0] & m}, {8'h00, e});
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rc("ctrl_rst", OFS_CTRL, 8'hFF, 8'h00);
    rc("cnt_rst", OFS_CNT_LO, 8'hFF, 8'h00);
    rc("rld_rst", OFS_RLD_HI, 8'hFF, 8'h00);
    rd(8'h1C);
    chk("bad_resp", {14'h0000, rd_r}, {14'h0000, RESP_SLVERR});
    wr(8'h1C, 8'hFF);
    chk("bad_wr", {14'h0000, wr_r}, {14'h0000, RESP_SLVERR});
  endtask

  task automatic t_wide();
    wr(OFS_CKSEL, 8'h10);
    chk("wr_ok", {14'h0000, wr_r}, {14'h0000, RESP_OKAY});
    wr(OFS_IEN, 8'h20);
    wr(OFS_RLD_HI, 8'hAB);
    wr(OFS_CNT_LO, 8'hF0);
    wr(OFS_CNT_HI, 8'hFF);
    wr(OFS_CTRL, 8'h04);
    repeat (40) @(posedge aclk);
    rc("ctrl16", OFS_CTRL, 8'hFF, 8'hC4);
    chk("irq16", irq, 1'b1);
    wr(OFS_CTRL, 8'h00);
    rc("reload16", OFS_CNT_HI, 8'hFF, 8'hAB);
    rd(OFS_CNT_LO);
    cnt = rd_d[15:0];
    repeat (20) @(posedge aclk);
    rc("hold16", OFS_CNT_LO, 8'hFF, cnt[7:0]);
    chk("irq_clr", irq, 1'b0);
  endtask

  task automatic t_low_irq();
    wr(OFS_CNT_LO, 8'hF0);
    wr(OFS_CTRL, 8'h24);
    repeat (30) @(posedge aclk);
    rc("ctrl_lo", OFS_CTRL, 8'hFF, 8'h64);
    chk("irq_lo", irq, 1'b1);
    wr(OFS_CTRL, 8'h04);
    wr(OFS_CNT_LO, 8'hF0);
    repeat (30) @(posedge aclk);
    rc("ctrl_lo2", OFS_CTRL, 8'hFF, 8'h44);
    chk("irq_lo2", irq, 1'b0);
    wr(OFS_CTRL, 8'h00);
  endtask

  task automatic t_split();
    wr(OFS_CKSEL, 8'h30);
    wr(OFS_RLD_LO, 8'h80);
    wr(OFS_RLD_HI, 8'h40);
    wr(OFS_CNT_HI, 8'hFC);
    wr(OFS_CNT_LO, 8'hF8);
    wr(OFS_CTRL, 8'h08);
    repeat (30) @(posedge aclk);
    rc("ctrl_sp", OFS_CTRL, 8'hFF, 8'h48);
    rc("hi_gated", OFS_CNT_HI, 8'hFF, 8'hFC);
    rc("lo_reload", OFS_CNT_LO, 8'hC0, 8'h80);
    chk("irq_sp", irq, 1'b0);
    wr(OFS_CTRL, 8'h0C);
    repeat (30) @(posedge aclk);
    rc("ctrl_sp2", OFS_CTRL, 8'hC0, 8'h80);
    rc("hi_reload", OFS_CNT_HI, 8'hC0, 8'h40);
    chk("irq_sp2", irq, 1'b1);
    wr(OFS_CTRL, 8'h00);
  endtask

  // Slow clocks: tick counts allow one tick of phase either way
  task automatic t_slow();
    wr(OFS_CKSEL, 8'h00);
    wr(OFS_CNT_HI, 8'h00);
    wr(OFS_CNT_LO, 8'h00);
    wr(OFS_CTRL, 8'h04);
    repeat (240) @(posedge aclk);
    wr(OFS_CTRL, 8'h00);
    rd(OFS_CNT_LO);
    chk("div12", rd_d >= 19 && rd_d <= 21, 1'b1);
    ext_en <= 1'b1;
    wr(OFS_CNT_LO, 8'h00);
    wr(OFS_CTRL, 8'h05);
    repeat (800) @(posedge aclk);
    wr(OFS_CTRL, 8'h01);
    rd(OFS_CNT_LO);
    chk("ext8", rd_d >= 9 && rd_d <= 11, 1'b1);
  endtask

  task automatic t_cap();
    wr(OFS_CKSEL, 8'h10);
    wr(OFS_CNT_LO, 8'h00);
    wr(OFS_CNT_HI, 8'h00);
    wr(OFS_CTRL, 8'h14);
    repeat (200) @(posedge aclk);
    ext_en <= 1'b0;
    repeat (100) @(posedge aclk);
    rc("cap_flag", OFS_CTRL, 8'h80, 8'h80);
    rd(OFS_RLD_LO);
    cap[7:0] = rd_d[7:0];
    rd(OFS_RLD_HI);
    cap[15:8] = rd_d[7:0];
    chk("cap_val", cap != 16'h0000 && cap <= 16'h012C, 1'b1);
    rd(OFS_CNT_LO);
    cnt[7:0] = rd_d[7:0];
    rd(OFS_CNT_HI);
    cnt[15:8] = rd_d[7:0];
    chk("cap_run", cnt > cap + 16'h0064, 1'b1);
    // Clock enable low must freeze the running count
    ce <= 1'b0;
    repeat (100) @(posedge aclk);
    ce <= 1'b1;
    rd(OFS_CNT_LO);
    chk("ce_hold", 8'(rd_d[7:0] - cnt[7:0]) < 8'h10, 1'b1);
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    $display("Error watchdog expected done seen timeout");
    summarize();
  end

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_wide();
    t_low_irq();
    t_split();
    t_slow();
    t_cap();
    summarize();
  end
endmodule // tb
